// File: src/emi_params.svh
// Constants of the external memory interface.
// Assumes a 250 MHz clock and byte register addresses.
//
// Summary of operation
// - 32-bit data bus, also 8 and 16 wide
// - Two SDRAM banks, one select each
// - Row strobe low for activate, precharge
// - Column strobe low for read, write
// - SDRAM write strobe separates write from read
// - Byte mask high ignores lane, low enables
// - Mask bit n governs data byte n
// - Three I/O banks, one select each
// - Each I/O window spans 16KB
// - Wait low stretches static and I/O access
// - Two static banks, one select each
// - Static banks remappable by software swap bit
// - SDRAM column bits programmable 8 to 11
// - SDRAM row/column on 12:0, bank 21:20
// - Address shifted for width, except I/O
// - Output enable, byte writes for static and I/O
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH

`define EMI_OFS_SDRAM_CFG 8'h00
`define EMI_OFS_STATIC_CFG 8'h04
`define EMI_OFS_IO_CFG 8'h08
`define EMI_OFS_STATUS 8'h0C

`define EMI_SD_COL_POS 0
`define EMI_SD_WIDTH_POS 2
`define EMI_ST_ACCESS_POS 0
`define EMI_ST_WIDTH0_POS 4
`define EMI_ST_WIDTH1_POS 6
`define EMI_ST_SWAP_POS 8
`define EMI_IO_ACCESS_POS 0
`define EMI_IO_WIDTH_POS 4

`define EMI_SDRAM_CFG_RESET 32'h0000_000C
`define EMI_STATIC_CFG_RESET 32'h0000_00FF
`define EMI_IO_CFG_RESET 32'h0000_003F

`define EMI_CLK_PERIOD_NS 4
`define EMI_T_RCD_NS 20
`define EMI_T_RP_NS 20
`define EMI_T_WR_NS 15
`define EMI_RCD_CYC ((`EMI_T_RCD_NS + `EMI_CLK_PERIOD_NS - 1) / `EMI_CLK_PERIOD_NS)
`define EMI_RP_CYC ((`EMI_T_RP_NS + `EMI_CLK_PERIOD_NS - 1) / `EMI_CLK_PERIOD_NS)
`define EMI_WR_CYC ((`EMI_T_WR_NS + `EMI_CLK_PERIOD_NS - 1) / `EMI_CLK_PERIOD_NS)
`define EMI_CAS_LAT 2
`define EMI_SYNC_LAT 4
`define EMI_MIN_STROBE 5

`endif

// File: src/emi_pkg.sv
// Types of the memory interface.
// Constants live in the header.
package emi_pkg;

   typedef enum logic [3:0] {
      EMI_ST_IDLE = 4'b0000,
      EMI_ST_SETUP = 4'b0001,
      EMI_ST_STROBE = 4'b0010,
      EMI_ST_RECOVER = 4'b0011,
      EMI_ST_ACTIVATE = 4'b0100,
      EMI_ST_RCD = 4'b0101,
      EMI_ST_COMMAND = 4'b0110,
      EMI_ST_LATENCY = 4'b0111,
      EMI_ST_PRECHARGE = 4'b1000,
      EMI_ST_RP = 4'b1001,
      EMI_ST_DONE = 4'b1010
   } emi_state_t;

   typedef enum logic [1:0] {
      EMI_RG_STATIC = 2'b00,
      EMI_RG_SDRAM = 2'b01,
      EMI_RG_IO = 2'b10,
      EMI_RG_NONE = 2'b11
   } emi_region_t;

   typedef struct packed {
      logic write;
      logic [25:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } emi_req_t;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
   } emi_sdram_cmd_t;

endpackage : emi_pkg

// File: src/emi_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input; output moves once stages two and three agree.
`timescale 1ns/10ps
module emi_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   // Per bit, so a settled lane is not held back by a moving one
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= RESET_VALUE;
         stage2 <= RESET_VALUE;
         stage3 <= RESET_VALUE;
         level <= RESET_VALUE;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= (stage3 & agree) | (level & ~agree);
      end
   end

endmodule : emi_pin_sync

// File: src/emi_memory_interface.sv
// External memory interface: SDRAM, static memory and memory-mapped I/O banks on shared pins.
// Assumes a single 250 MHz clock, a plain config register port and a one-at-a-time request port.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "emi_params.svh"
module emi_memory_interface
   import emi_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic req_valid,
   input wire emi_req_t req,
   output logic req_ready,
   output logic resp_done,
   output logic resp_error,
   output logic [31:0] resp_rdata,
   output logic [21:0] mem_addr,
   input wire logic [31:0] data_in,
   output logic [31:0] data_out,
   output logic [31:0] data_oe,
   output logic [1:0] sdram_bank_select_n,
   output logic sdram_row_strobe_n,
   output logic sdram_column_strobe_n,
   output logic sdram_write_strobe_n,
   output logic [3:0] sdram_byte_mask,
   output logic [2:0] io_bank_select_n,
   output logic [1:0] static_bank_select_n,
   output logic [3:0] static_byte_write_n,
   output logic static_output_enable_n,
   input wire logic external_wait_n
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers

   logic rst_meta_n;
   logic rst_n;
   logic wait_level_n;
   logic [31:0] data_sync;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   emi_pin_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_wait_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin(external_wait_n),
      .level(wait_level_n)
   );

   emi_pin_sync #(.WIDTH(32), .RESET_VALUE(32'h0000_0000)) u_data_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin(data_in),
      .level(data_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   logic [31:0] sdram_cfg;
   logic [31:0] static_cfg;
   logic [31:0] io_cfg;
   emi_state_t state;
   logic [31:0] status_word;
   logic [31:0] read_mux;
   logic [3:0] col_bits;

   assign col_bits = 4'd8 + {2'b00, sdram_cfg[`EMI_SD_COL_POS +: 2]};
   assign status_word = {26'h000_0000, ~wait_level_n, state, state != EMI_ST_IDLE};
   assign read_mux = (reg_addr == `EMI_OFS_SDRAM_CFG) ? sdram_cfg :
                     (reg_addr == `EMI_OFS_STATIC_CFG) ? static_cfg :
                     (reg_addr == `EMI_OFS_IO_CFG) ? io_cfg :
                     (reg_addr == `EMI_OFS_STATUS) ? status_word : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdram_cfg <= `EMI_SDRAM_CFG_RESET;
         static_cfg <= `EMI_STATIC_CFG_RESET;
         io_cfg <= `EMI_IO_CFG_RESET;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         if (reg_write && reg_addr == `EMI_OFS_SDRAM_CFG)
            sdram_cfg <= {28'h000_0000, reg_wdata[3:0]};
         if (reg_write && reg_addr == `EMI_OFS_STATIC_CFG)
            static_cfg <= {23'h00_0000, reg_wdata[8:0]};
         if (reg_write && reg_addr == `EMI_OFS_IO_CFG)
            io_cfg <= {26'h000_0000, reg_wdata[5:0]};
         reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Request decode: 16MB static, 16MB SDRAM, three 16KB I/O windows

   function automatic emi_region_t region_of(input logic [25:0] addr);
      if (addr[25:24] == 2'b00)
         return EMI_RG_STATIC;
      else if (addr[25:24] == 2'b01)
         return EMI_RG_SDRAM;
      else if (addr[25:24] == 2'b10 && addr[15:14] != 2'b11)
         return EMI_RG_IO;
      else
         return EMI_RG_NONE;
   endfunction : region_of

   emi_req_t cur;
   emi_region_t region;
   logic [1:0] beat;
   logic [4:0] cnt;
   logic [31:0] acc;
   logic cur_err;
   logic static_bank;
   logic [1:0] width_code;
   logic [1:0] shift;
   logic [1:0] last_beat;
   logic [1:0] offset;
   logic [25:0] beat_addr;
   logic [25:0] unit_addr;
   logic [3:0] width_lanes;
   logic [3:0] beat_be;
   logic [31:0] lane32;
   logic [31:0] beat_wdata;
   logic [3:0] access_cfg;
   logic [4:0] strobe_len;

   assign static_bank = cur.addr[23] ^ static_cfg[`EMI_ST_SWAP_POS];
   assign width_code = (region == EMI_RG_SDRAM) ? sdram_cfg[`EMI_SD_WIDTH_POS +: 2] :
                       (region == EMI_RG_IO) ? io_cfg[`EMI_IO_WIDTH_POS +: 2] :
                       static_bank ? static_cfg[`EMI_ST_WIDTH1_POS +: 2] :
                       static_cfg[`EMI_ST_WIDTH0_POS +: 2];
   // Reserved width code falls back to full word
   assign shift = (width_code == 2'b01) ? 2'd0 : (width_code == 2'b10) ? 2'd1 : 2'd2;
   assign last_beat = (shift == 2'd0) ? 2'd3 : (shift == 2'd1) ? 2'd1 : 2'd0;
   assign offset = 2'(beat << shift);
   assign beat_addr = {cur.addr[25:2], offset};
   assign unit_addr = beat_addr >> shift;
   assign width_lanes = (shift == 2'd0) ? 4'h1 : (shift == 2'd1) ? 4'h3 : 4'hF;
   assign beat_be = (cur.be >> offset) & width_lanes;
   assign lane32 = {{8{width_lanes[3]}}, {8{width_lanes[2]}}, {8{width_lanes[1]}}, {8{width_lanes[0]}}};
   assign beat_wdata = (cur.wdata >> {offset, 3'b000}) & lane32;
   assign access_cfg = (region == EMI_RG_IO) ? io_cfg[`EMI_IO_ACCESS_POS +: 4] :
                       static_cfg[`EMI_ST_ACCESS_POS +: 4];
   // Strobe must outlast the sync delay, or wait and read data would be seen too late
   assign strobe_len = ({1'b0, access_cfg} > 5'(`EMI_MIN_STROBE)) ? {1'b0, access_cfg} : 5'(`EMI_MIN_STROBE);

   // SDRAM row, column and bank from the width-adjusted unit address
   logic [12:0] sd_row;
   logic [12:0] sd_col;
   logic [1:0] sd_bank;
   logic [23:0] col_mask;

   assign col_mask = ~(24'hFF_FFFF << col_bits);
   assign sd_col = 13'(unit_addr[23:0] & col_mask);
   assign sd_row = 13'(unit_addr[23:0] >> col_bits);
   assign sd_bank = 2'(unit_addr[23:0] >> ({1'b0, col_bits} + 5'd13));

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   emi_state_t next_state;
   logic [4:0] next_cnt;
   logic [1:0] next_beat;
   logic [31:0] next_acc;
   logic sample;
   logic beat_end;

   assign req_ready = (state == EMI_ST_IDLE);
   assign sample = !cur.write && ((state == EMI_ST_STROBE && cnt >= strobe_len - 5'd1 && wait_level_n) ||
                   (state == EMI_ST_LATENCY && cnt >= 5'(`EMI_CAS_LAT + `EMI_SYNC_LAT - 1)));
   assign beat_end = (beat == last_beat);

   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 5'd1;
      next_beat = beat;
      next_acc = sample ? (acc | ((data_sync & lane32) << {offset, 3'b000})) : acc;
      unique case (state)
         EMI_ST_IDLE:
         begin
            next_cnt = 5'd0;
            next_beat = 2'd0;
            if (req_valid)
            begin
               next_acc = 32'h0000_0000;
               next_state = (region_of(req.addr) == EMI_RG_NONE) ? EMI_ST_DONE :
                            (region_of(req.addr) == EMI_RG_SDRAM) ? EMI_ST_ACTIVATE : EMI_ST_SETUP;
            end
         end
         EMI_ST_SETUP:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_STROBE;
         end
         EMI_ST_STROBE:
         begin
            // Wait low holds the strobe past the programmed time
            if (cnt >= strobe_len - 5'd1 && wait_level_n)
            begin
               next_cnt = 5'd0;
               next_state = EMI_ST_RECOVER;
            end
         end
         EMI_ST_RECOVER:
         begin
            next_cnt = 5'd0;
            next_beat = beat + 2'd1;
            next_state = beat_end ? EMI_ST_DONE : EMI_ST_SETUP;
         end
         EMI_ST_ACTIVATE:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_RCD;
         end
         EMI_ST_RCD:
         begin
            if (cnt >= 5'(`EMI_RCD_CYC - 2))
            begin
               next_cnt = 5'd0;
               next_state = EMI_ST_COMMAND;
            end
         end
         EMI_ST_COMMAND:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_LATENCY;
         end
         EMI_ST_LATENCY:
         begin
            if (sample || (cur.write && cnt >= 5'(`EMI_WR_CYC - 1)))
            begin
               next_cnt = 5'd0;
               next_state = EMI_ST_PRECHARGE;
            end
         end
         EMI_ST_PRECHARGE:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_RP;
         end
         EMI_ST_RP:
         begin
            if (cnt >= 5'(`EMI_RP_CYC - 2))
            begin
               next_cnt = 5'd0;
               next_beat = beat + 2'd1;
               next_state = beat_end ? EMI_ST_DONE : EMI_ST_ACTIVATE;
            end
         end
         EMI_ST_DONE:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_IDLE;
         end
         default:
         begin
            next_cnt = 5'd0;
            next_state = EMI_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= EMI_ST_IDLE;
         cnt <= 5'd0;
         beat <= 2'd0;
         acc <= 32'h0000_0000;
         cur <= '0;
         region <= EMI_RG_NONE;
         cur_err <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         beat <= next_beat;
         acc <= next_acc;
         if (req_ready && req_valid)
         begin
            cur <= req;
            region <= region_of(req.addr);
            cur_err <= (region_of(req.addr) == EMI_RG_NONE);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resp_done <= 1'b0;
         resp_error <= 1'b0;
         resp_rdata <= 32'h0000_0000;
      end
      else
      begin
         resp_done <= (state == EMI_ST_DONE);
         resp_error <= (state == EMI_ST_DONE) && cur_err;
         if (state == EMI_ST_DONE)
            resp_rdata <= cur.write ? 32'h0000_0000 : acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin drive, one cycle behind the sequencer state

   logic st_phase;
   logic sd_phase;
   logic drive;
   emi_sdram_cmd_t next_cmd;
   logic [21:0] next_addr;

   assign st_phase = (state == EMI_ST_SETUP || state == EMI_ST_STROBE || state == EMI_ST_RECOVER);
   assign sd_phase = (state >= EMI_ST_ACTIVATE && state <= EMI_ST_RP);
   assign drive = cur.write && ((st_phase && region != EMI_RG_SDRAM) || state == EMI_ST_COMMAND);
   assign next_cmd = (state == EMI_ST_ACTIVATE) ? 3'b011 :
                     (state == EMI_ST_COMMAND) ? {2'b10, ~cur.write} :
                     (state == EMI_ST_PRECHARGE) ? 3'b010 : 3'b111;
   assign next_addr = (region == EMI_RG_IO && st_phase) ? {8'h00, beat_addr[13:0]} :
                      (region == EMI_RG_STATIC && st_phase) ? unit_addr[21:0] :
                      (state == EMI_ST_ACTIVATE) ? {sd_bank, 7'h00, sd_row} :
                      (state == EMI_ST_COMMAND) ? {sd_bank, 7'h00, sd_col} :
                      (state == EMI_ST_PRECHARGE) ? 22'h00_0400 : 22'h00_0000;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_addr <= 22'h00_0000;
         data_out <= 32'h0000_0000;
         data_oe <= 32'h0000_0000;
         sdram_bank_select_n <= 2'b11;
         {sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n} <= 3'b111;
         sdram_byte_mask <= 4'hF;
         io_bank_select_n <= 3'b111;
         static_bank_select_n <= 2'b11;
         static_byte_write_n <= 4'hF;
         static_output_enable_n <= 1'b1;
      end
      else
      begin
         mem_addr <= next_addr;
         data_out <= beat_wdata;
         data_oe <= drive ? lane32 : 32'h0000_0000;
         // Region holds one encoded value, so a single select at most
         sdram_bank_select_n <= ~((sd_phase && region == EMI_RG_SDRAM) ? (2'b01 << cur.addr[23]) : 2'b00);
         io_bank_select_n <= ~((st_phase && region == EMI_RG_IO) ? (3'b001 << cur.addr[15:14]) : 3'b000);
         static_bank_select_n <= ~((st_phase && region == EMI_RG_STATIC) ? (2'b01 << static_bank) : 2'b00);
         {sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n} <= next_cmd;
         sdram_byte_mask <= sd_phase ? ~beat_be : 4'hF;
         static_byte_write_n <= ~((state == EMI_ST_STROBE && cur.write) ? beat_be : 4'h0);
         static_output_enable_n <= ~(state == EMI_ST_STROBE && !cur.write);
      end
   end

endmodule : emi_memory_interface

// File: tb/emi_mem_model.sv
// Far-side model: memory devices on the shared data bus and the wait line.
// Assumes the bench leaves the bus level at data_in to this model.
`timescale 1ns/10ps
module emi_mem_model
   import emi_pkg::*;
#(
   parameter logic [31:0] WORD = 32'hA5C3_0F96,
   parameter int STALL = 24
) (
   input wire logic clock,
   input wire logic stall,
   input wire logic [31:0] data_out,
   input wire logic [31:0] data_oe,
   input wire logic [1:0] sdram_bank_select_n,
   input wire logic sdram_column_strobe_n,
   input wire logic sdram_write_strobe_n,
   input wire logic [3:0] sdram_byte_mask,
   input wire logic [2:0] io_bank_select_n,
   input wire logic [1:0] static_bank_select_n,
   input wire logic static_output_enable_n,
   input wire logic [3:0] static_byte_write_n,
   output logic [31:0] data_in,
   output logic external_wait_n
);
   logic sd_reading = 1'b0;
   logic [31:0] last = '0;
   int wait_cnt = 0;
   wire logic static_sel = (static_bank_select_n != 2'b11) || (io_bank_select_n != 3'b111);
   wire logic strobe_on = static_sel && (!static_output_enable_n || static_byte_write_n != 4'hF);
   // Read lanes: static enable, SDRAM mask low
   wire logic [3:0] lanes = (static_sel && !static_output_enable_n) ? 4'hF :
      (sd_reading ? ~sdram_byte_mask : 4'h0);
   ////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      last <= data_in;
      wait_cnt <= strobe_on ? wait_cnt + 1 : 0;
      if (sdram_bank_select_n == 2'b11)
         sd_reading <= 1'b0;
      else if (!sdram_column_strobe_n && sdram_write_strobe_n)
         sd_reading <= 1'b1;
   end
   // Stall outlasts the strobe so late-synced wait bites
   assign external_wait_n = !(stall && strobe_on && wait_cnt < STALL);
   // Undriven lanes flip so stale data never matches
   always_comb
   begin
      for (int b = 0; b < 32; b++)
      begin
         data_in[b] = data_oe[b] ? data_out[b] : (lanes[b / 8] ? WORD[b] : ~last[b]);
      end
   end
endmodule : emi_mem_model

// File: tb/emi_memory_interface_asserts.sv
// Pin checks bound to the memory interface.
// Sees the top ports only; reset is raw rstn.
`timescale 1ns/10ps
module emi_memory_interface_asserts (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [21:0] mem_addr,
   input wire logic [31:0] data_oe,
   input wire logic [1:0] sdram_bank_select_n,
   input wire logic sdram_row_strobe_n,
   input wire logic sdram_column_strobe_n,
   input wire logic sdram_write_strobe_n,
   input wire logic [2:0] io_bank_select_n,
   input wire logic [1:0] static_bank_select_n,
   input wire logic [3:0] static_byte_write_n,
   input wire logic static_output_enable_n,
   input wire logic external_wait_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   a_one_select_low: assert property ($countones({~io_bank_select_n, ~sdram_bank_select_n,
      ~static_bank_select_n}) <= 1) else $error("More than one bank select low");
   a_byte_write_static: assert property (static_byte_write_n != 4'hF |-> sdram_bank_select_n == 2'b11
      && (static_bank_select_n != 2'b11 || io_bank_select_n != 3'b111)) else $error("Byte write outside static");
   a_read_bus_free: assert property (!static_output_enable_n |-> data_oe == 32'h0)
      else $error("Data bus driven during static read");
   a_row_selected: assert property (!sdram_row_strobe_n |-> sdram_bank_select_n != 2'b11)
      else $error("Row strobe with no SDRAM bank selected");
   a_column_selected: assert property (!sdram_column_strobe_n |-> sdram_bank_select_n != 2'b11
      && static_output_enable_n) else $error("Column strobe without SDRAM select");
   a_write_drives: assert property (!sdram_column_strobe_n && !sdram_write_strobe_n |-> ##[0:1]
      data_oe != 32'h0) else $error("SDRAM write without data driven");
   a_read_released: assert property (!sdram_column_strobe_n && sdram_write_strobe_n |->
      data_oe == 32'h0) else $error("SDRAM read with data driven");
   a_strobe_min: assert property ($fell(static_output_enable_n) |-> !static_output_enable_n[*5])
      else $error("Output enable strobe too short");
   a_wait_stretches: assert property ((!external_wait_n && !static_output_enable_n)[*6] |=>
      !static_output_enable_n) else $error("Strobe ended while wait held low");
   a_precharge_all: assert property (!sdram_row_strobe_n && !sdram_write_strobe_n &&
      sdram_column_strobe_n |-> mem_addr[10]) else $error("Precharge without A10 high");
endmodule : emi_memory_interface_asserts
bind emi_memory_interface emi_memory_interface_asserts i_asserts (.clock, .rstn, .mem_addr, .data_oe,
   .sdram_bank_select_n, .sdram_row_strobe_n, .sdram_column_strobe_n, .sdram_write_strobe_n,
   .io_bank_select_n, .static_bank_select_n, .static_byte_write_n, .static_output_enable_n, .external_wait_n);

// File: tb/test_external_memory_interface_pins.sv
// Self-checking bench for the memory interface.
// Assumes the design's reset and handshake contracts.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module test_external_memory_interface_pins
   import emi_pkg::*;
;
   localparam logic [31:0] MEM_WORD = 32'hA5C3_0F96;
   typedef struct packed {emi_req_t rq; logic err; logic [31:0] rd; logic [6:0] sel;} emi_row_t;
   // Select order: io[2:0], sdram[1:0], static[1:0]
   emi_row_t rows [9] = '{
      '{'{1'b0, 26'h000_0010, 32'h0, 4'hF}, 1'b0, MEM_WORD, 7'h01},
      '{'{1'b1, 26'h080_0010, 32'h1357_9BDF, 4'hF}, 1'b0, 32'h0, 7'h02},
      '{'{1'b0, 26'h100_0040, 32'h0, 4'hF}, 1'b0, MEM_WORD, 7'h04},
      '{'{1'b1, 26'h180_0040, 32'h0F0F_5A5A, 4'hF}, 1'b0, 32'h0, 7'h08},
      '{'{1'b0, 26'h200_0004, 32'h0, 4'hF}, 1'b0, MEM_WORD, 7'h10},
      '{'{1'b0, 26'h200_4004, 32'h0, 4'hF}, 1'b0, MEM_WORD, 7'h20},
      '{'{1'b1, 26'h200_8004, 32'hC0DE_0001, 4'hF}, 1'b0, 32'h0, 7'h40},
      '{'{1'b0, 26'h200_C004, 32'h0, 4'hF}, 1'b1, 32'h0, 7'h00},
      '{'{1'b0, 26'h300_0000, 32'h0, 4'hF}, 1'b1, 32'h0, 7'h00}};
   logic clock = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, req_valid = 1'b0, stall = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, resp_rdata, data_in, data_out, data_oe;
   emi_req_t req = '0;
   logic req_ready, resp_done, resp_error, sdram_row_strobe_n, sdram_column_strobe_n, sdram_write_strobe_n;
   logic static_output_enable_n, external_wait_n, swr_q = 1'b1;
   logic [21:0] mem_addr;
   logic [1:0] sdram_bank_select_n, static_bank_select_n;
   logic [2:0] io_bank_select_n;
   logic [3:0] sdram_byte_mask, static_byte_write_n, col_mask = '0;
   logic [6:0] seen = '0;
   int err_total = 0, n_compared = 0, oe_cnt = 0, wr_falls = 0;
   always #2 clock = ~clock;
   emi_memory_interface i_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .req_valid, .req, .req_ready, .resp_done, .resp_error, .resp_rdata, .mem_addr, .data_in, .data_out,
      .data_oe, .sdram_bank_select_n, .sdram_row_strobe_n, .sdram_column_strobe_n, .sdram_write_strobe_n,
      .sdram_byte_mask, .io_bank_select_n, .static_bank_select_n, .static_byte_write_n,
      .static_output_enable_n, .external_wait_n);
   emi_mem_model #(.WORD(MEM_WORD), .STALL(24)) i_mem (.clock, .stall, .data_out, .data_oe,
      .sdram_bank_select_n, .sdram_column_strobe_n, .sdram_write_strobe_n, .sdram_byte_mask,
      .io_bank_select_n, .static_bank_select_n, .static_output_enable_n, .static_byte_write_n,
      .data_in, .external_wait_n);
   ////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      seen <= seen | ~{io_bank_select_n, sdram_bank_select_n, static_bank_select_n};
      oe_cnt <= oe_cnt + int'(!static_output_enable_n);
      wr_falls <= wr_falls + int'(swr_q && !static_byte_write_n[0]);
      swr_q <= static_byte_write_n[0];
      if (!sdram_column_strobe_n)
         col_mask <= sdram_byte_mask;
   end
   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic bound(input int n);
      if (n > 500)
      begin
         err_total++;
         $display("BAD handshake timeout");
         finish_test();
      end
   endtask : bound
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_rd
   task automatic access(input emi_req_t r, output logic err, output logic [31:0] rd);
      int n;
      @(posedge clock);
      #1;
      seen = '0;
      oe_cnt = 0;
      wr_falls = 0;
      @(posedge clock);
      req <= r;
      req_valid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         bound(n++);
      end
      while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      while (resp_done !== 1'b1)
      begin
         @(posedge clock);
         #1;
         bound(n++);
      end
      err = resp_error;
      rd = resp_rdata;
   endtask : access
   initial
   begin
      logic e;
      logic [31:0] d;
      int a;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      foreach (rows[i])
      begin
         access(rows[i].rq, e, d);
         `CHK("error", rows[i].err, e)
         `CHK("selects", rows[i].sel, seen)
         if (!rows[i].err)
            `CHK("rdata", rows[i].rd, d)
      end
      $display("Bank table done");
      reg_wr(8'h14, 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++)
      begin
         reg_rd(i == 3 ? 8'h14 : 8'(i * 4), d);
         `CHK("config reset", i == 0 ? 32'h0000_000C : i == 1 ? 32'h0000_00FF : i == 2 ? 32'h0000_003F : 32'h0, d)
      end
      reg_wr(8'h00, 32'h0000_000F);
      reg_rd(8'h00, d);
      `CHK("column bits", 32'h0000_000F, d)
      $display("Register test done");
      reg_wr(8'h04, 32'h0000_01FF);
      access(rows[0].rq, e, d);
      `CHK("swapped select", 7'h02, seen)
      $display("Swap test done");
      for (int w = 1; w < 4; w++)
      begin
         reg_wr(8'h04, 32'h0000_00CF | (32'(w) << 4));
         access('{1'b1, 26'h000_0020, 32'h1357_9BDF, 4'hF}, e, d);
         `CHK("beats", (w == 1) ? 4 : (w == 2) ? 2 : 1, wr_falls)
      end
      reg_wr(8'h04, 32'h0000_00FF);
      $display("Width test done");
      access('{1'b1, 26'h100_0080, 32'h2468_ACE0, 4'b0101}, e, d);
      `CHK("write mask", 4'b1010, col_mask)
      access('{1'b0, 26'h100_0080, 32'h0, 4'b0011}, e, d);
      `CHK("read mask", 4'b1100, col_mask)
      `CHK("read lanes", MEM_WORD[15:0], d[15:0])
      $display("Mask test done");
      access(rows[0].rq, e, d);
      a = oe_cnt;
      @(posedge clock);
      stall <= 1'b1;
      access(rows[0].rq, e, d);
      `CHK("stretched", 1'b1, oe_cnt > a)
      `CHK("stalled rdata", MEM_WORD, d)
      @(posedge clock);
      stall <= 1'b0;
      $display("Wait test done");
      @(posedge clock);
      rstn <= 1'b0;
      @(posedge clock);
      #1;
      `CHK("reset selects", 7'h7F, {io_bank_select_n, sdram_bank_select_n, static_bank_select_n})
      `CHK("reset bus", 32'h0, data_oe)
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      access(rows[2].rq, e, d);
      `CHK("rdata after reset", MEM_WORD, d)
      $display("Second reset test done");
      finish_test();
   end
endmodule : test_external_memory_interface_pins
